//--- rtl/coag_pkg.sv
// coag_pkg: shared types and constants for the operand address generator
// assumes: an 8-bit core with a 16-bit byte address space
package coag_pkg;

  // addressing modes handled by the generator
  typedef enum logic [2:0] {
    MODE_NONE = 3'b000,
    MODE_EXT = 3'b001,
    MODE_IX = 3'b010,
    MODE_IX1 = 3'b011,
    MODE_IX2 = 3'b100,
    MODE_REL = 3'b101,
    MODE_BSC = 3'b110,
    MODE_BTB = 3'b111
  } coag_mode_t;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BYTE1 = 2'b01,
    ST_BYTE2 = 2'b10,
    ST_OPND = 2'b11
  } coag_state_t;

  // opcode high nibble per mode column
  localparam logic [3:0] NIB_BTB = 4'h0;
  localparam logic [3:0] NIB_BSC = 4'h1;
  localparam logic [3:0] NIB_REL = 4'h2;
  localparam logic [3:0] NIB_IX1_RMW = 4'h6;
  localparam logic [3:0] NIB_IX_RMW = 4'h7;
  localparam logic [3:0] NIB_EXT = 4'hC;
  localparam logic [3:0] NIB_IX2 = 4'hD;
  localparam logic [3:0] NIB_IX1 = 4'hE;
  localparam logic [3:0] NIB_IX = 4'hF;

  // field positions inside the opcode
  localparam int BIT_NUM_LSB = 1;
  localparam int BIT_SENSE_POS = 0;

  // instruction lengths and branch bases, in bytes
  localparam logic [15:0] LEN_ONE = 16'h0001;
  localparam logic [15:0] LEN_TWO = 16'h0002;
  localparam logic [15:0] LEN_THREE = 16'h0003;

  // reset value and zero-page high byte
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] ZERO_PAGE = 8'h00;

  // sign-extend a branch offset to the address width
  function automatic logic [15:0] coag_sext(input logic [7:0] off);
    coag_sext = {{8{off[7]}}, off};
  endfunction : coag_sext

endpackage : coag_pkg

//--- rtl/coag_mode_decode.sv
// coag_mode_decode: classifies an opcode into its addressing mode and bit fields
// assumes: opcode is stable for the cycle it is sampled, same clock domain
`timescale 1ns/10ps
module coag_mode_decode
  import coag_pkg::*;
(
  input wire logic [7:0] opcode,
  output coag_mode_t mode,
  output logic [2:0] bit_number,
  output logic bit_sense
);

  // only the branch column maps to relative mode
  function automatic coag_mode_t classify(input logic [7:0] op);
    coag_mode_t m;
    m = MODE_NONE;
    if (op[7:4] == NIB_BTB) begin
      m = MODE_BTB;
    end else if (op[7:4] == NIB_BSC) begin
      m = MODE_BSC;
    end else if (op[7:4] == NIB_REL) begin
      m = MODE_REL;
    end else if (op[7:4] == NIB_EXT) begin
      m = MODE_EXT;
    end else if (op[7:4] == NIB_IX2) begin
      m = MODE_IX2;
    end else if (op[7:4] == NIB_IX1 || op[7:4] == NIB_IX1_RMW) begin
      m = MODE_IX1;
    end else if (op[7:4] == NIB_IX || op[7:4] == NIB_IX_RMW) begin
      m = MODE_IX;
    end
    classify = m;
  endfunction : classify

  // bit number straight from the opcode, sense from its inverted bit 0
  always_comb begin
    mode = classify(opcode);
    bit_number = opcode[BIT_NUM_LSB +: 3];
    bit_sense = ~opcode[BIT_SENSE_POS];
  end

endmodule : coag_mode_decode

//--- rtl/coag_operand_address_generator.sv
// coag_operand_address_generator: operand address and program counter sequencer
// assumes: memory answers a read in the cycle mem_ready is high; opcode already fetched
`timescale 1ns/10ps
module coag_operand_address_generator
  import coag_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic pc_load,
  input wire logic [15:0] pc_value,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] index_reg,
  input wire logic branch_cond,
  output logic mem_rd,
  output logic [15:0] mem_addr,
  input wire logic mem_ready,
  input wire logic [7:0] mem_rdata,
  output logic busy,
  output logic done,
  output logic bad_mode,
  output logic [15:0] effective_address,
  output logic [15:0] program_counter,
  output logic [15:0] tested_byte_address,
  output logic [2:0] bit_number,
  output logic carry_out,
  output logic carry_valid
);

  coag_mode_t dec_mode;
  logic [2:0] dec_bit;
  logic dec_sense;

  coag_state_t state_ff, nxt_state;
  coag_mode_t mode_ff, nxt_mode;
  logic [15:0] pc_ff, nxt_pc;
  logic [15:0] op_addr_ff, nxt_op_addr;
  logic [15:0] mem_addr_ff, nxt_mem_addr;
  logic [15:0] ea_ff, nxt_ea;
  logic [15:0] tba_ff, nxt_tba;
  logic [7:0] byte1_ff, nxt_byte1;
  logic [7:0] byte2_ff, nxt_byte2;
  logic [7:0] index_ff, nxt_index;
  logic [7:0] opcode_ff, nxt_opcode;
  logic [2:0] bit_ff, nxt_bit;
  logic sense_ff, nxt_sense;
  logic cond_ff, nxt_cond;
  logic done_ff, nxt_done;
  logic bad_ff, nxt_bad;
  logic carry_ff, nxt_carry;
  logic cvalid_ff, nxt_cvalid;
  logic rd_take;
  logic [8:0] ix1_sum;
  logic [15:0] rel_target;
  logic [15:0] btb_target;
  logic tested_bit;

  coag_mode_decode u_decode (
    .opcode(opcode),
    .mode(dec_mode),
    .bit_number(dec_bit),
    .bit_sense(dec_sense)
  );

  // bus handshake: a read is accepted while ready and enabled
  assign mem_rd = (state_ff != ST_IDLE);
  assign rd_take = clk_en && mem_rd && mem_ready;
  assign busy = mem_rd;

  // address arithmetic, all modulo 16 bits
  assign ix1_sum = {1'b0, index_ff} + {1'b0, mem_rdata};
  assign rel_target = op_addr_ff + LEN_TWO + coag_sext(mem_rdata);
  assign btb_target = op_addr_ff + LEN_THREE + coag_sext(byte2_ff);
  assign tested_bit = mem_rdata[bit_ff];

  // sequencer next-state and datapath
  always_comb begin
    nxt_state = state_ff;
    nxt_mode = mode_ff;
    nxt_pc = pc_ff;
    nxt_op_addr = op_addr_ff;
    nxt_mem_addr = mem_addr_ff;
    nxt_ea = ea_ff;
    nxt_tba = tba_ff;
    nxt_byte1 = byte1_ff;
    nxt_byte2 = byte2_ff;
    nxt_index = index_ff;
    nxt_opcode = opcode_ff;
    nxt_bit = bit_ff;
    nxt_sense = sense_ff;
    nxt_cond = cond_ff;
    nxt_done = 1'b0;
    nxt_bad = 1'b0;
    nxt_carry = carry_ff;
    nxt_cvalid = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (pc_load) begin
          nxt_pc = pc_value;
        end else if (start) begin
          nxt_mode = dec_mode;
          nxt_op_addr = pc_ff;
          nxt_index = index_reg;
          nxt_opcode = opcode;
          nxt_bit = dec_bit;
          nxt_sense = dec_sense;
          nxt_cond = branch_cond;
          if (dec_mode == MODE_NONE) begin
            nxt_done = 1'b1;
            nxt_bad = 1'b1;
          end else if (dec_mode == MODE_IX) begin
            nxt_ea = {ZERO_PAGE, index_reg};
            nxt_pc = pc_ff + LEN_ONE;
            nxt_done = 1'b1;
          end else begin
            nxt_mem_addr = pc_ff + LEN_ONE;
            nxt_state = ST_BYTE1;
          end
        end
      end
      ST_BYTE1: begin
        if (mem_ready) begin
          nxt_byte1 = mem_rdata;
          case (mode_ff)
            MODE_IX1: begin
              nxt_ea = {7'h00, ix1_sum};
              nxt_pc = op_addr_ff + LEN_TWO;
              nxt_done = 1'b1;
              nxt_state = ST_IDLE;
            end
            MODE_REL: begin
              nxt_ea = rel_target;
              nxt_pc = cond_ff ? rel_target : op_addr_ff + LEN_TWO;
              nxt_done = 1'b1;
              nxt_state = ST_IDLE;
            end
            MODE_BSC: begin
              nxt_ea = {ZERO_PAGE, mem_rdata};
              nxt_pc = op_addr_ff + LEN_TWO;
              nxt_done = 1'b1;
              nxt_state = ST_IDLE;
            end
            default: begin
              nxt_mem_addr = op_addr_ff + LEN_TWO;
              nxt_state = ST_BYTE2;
            end
          endcase
        end
      end
      ST_BYTE2: begin
        if (mem_ready) begin
          nxt_byte2 = mem_rdata;
          if (mode_ff == MODE_EXT) begin
            nxt_ea = {byte1_ff, mem_rdata};
            nxt_pc = op_addr_ff + LEN_THREE;
            nxt_done = 1'b1;
            nxt_state = ST_IDLE;
          end else if (mode_ff == MODE_IX2) begin
            nxt_ea = {byte1_ff, mem_rdata} + {ZERO_PAGE, index_ff};
            nxt_pc = op_addr_ff + LEN_THREE;
            nxt_done = 1'b1;
            nxt_state = ST_IDLE;
          end else begin
            nxt_tba = {ZERO_PAGE, byte1_ff};
            nxt_mem_addr = {ZERO_PAGE, byte1_ff};
            nxt_state = ST_OPND;
          end
        end
      end
      ST_OPND: begin
        if (mem_ready) begin
          nxt_carry = tested_bit;
          nxt_cvalid = 1'b1;
          nxt_ea = btb_target;
          nxt_pc = (tested_bit == sense_ff) ? btb_target : op_addr_ff + LEN_THREE;
          nxt_done = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // state registers, frozen while clk_en is low
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
      mode_ff <= MODE_NONE;
      pc_ff <= PC_RESET;
      op_addr_ff <= PC_RESET;
      mem_addr_ff <= PC_RESET;
      ea_ff <= 16'h0000;
      tba_ff <= 16'h0000;
      byte1_ff <= 8'h00;
      byte2_ff <= 8'h00;
      index_ff <= 8'h00;
      opcode_ff <= 8'h00;
      bit_ff <= 3'h0;
      sense_ff <= 1'b0;
      cond_ff <= 1'b0;
      done_ff <= 1'b0;
      bad_ff <= 1'b0;
      carry_ff <= 1'b0;
      cvalid_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      pc_ff <= nxt_pc;
      op_addr_ff <= nxt_op_addr;
      mem_addr_ff <= nxt_mem_addr;
      ea_ff <= nxt_ea;
      tba_ff <= nxt_tba;
      byte1_ff <= nxt_byte1;
      byte2_ff <= nxt_byte2;
      index_ff <= nxt_index;
      opcode_ff <= nxt_opcode;
      bit_ff <= nxt_bit;
      sense_ff <= nxt_sense;
      cond_ff <= nxt_cond;
      done_ff <= nxt_done;
      bad_ff <= nxt_bad;
      carry_ff <= nxt_carry;
      cvalid_ff <= nxt_cvalid;
    end
  end

  // registered outputs
  assign mem_addr = mem_addr_ff;
  assign done = done_ff;
  assign bad_mode = bad_ff;
  assign effective_address = ea_ff;
  assign program_counter = pc_ff;
  assign tested_byte_address = tba_ff;
  assign bit_number = bit_ff;
  assign carry_out = carry_ff;
  assign carry_valid = cvalid_ff;

  // checks on finished instructions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  logic fin_ff;
  assign fin_ff = done_ff && !bad_ff && clk_en;

  chk_ext_address: assert property (fin_ff && mode_ff == MODE_EXT |->
      ea_ff == {byte1_ff, byte2_ff} && pc_ff == op_addr_ff + LEN_THREE)
    else $error("extended address or step wrong");

  chk_ix_zero_page: assert property (fin_ff && mode_ff == MODE_IX |->
      ea_ff == {ZERO_PAGE, index_ff} && pc_ff == op_addr_ff + LEN_ONE)
    else $error("indexed no-offset address wrong");

  chk_ix1_carry_page: assert property (fin_ff && mode_ff == MODE_IX1 |->
      ea_ff < 16'h01FF && ea_ff == {ZERO_PAGE, index_ff} + {ZERO_PAGE, byte1_ff}
      && pc_ff == op_addr_ff + LEN_TWO)
    else $error("indexed byte-offset address wrong");

  chk_ix2_word_sum: assert property (fin_ff && mode_ff == MODE_IX2 |->
      ea_ff == {byte1_ff, byte2_ff} + {ZERO_PAGE, index_ff} && pc_ff == op_addr_ff + LEN_THREE)
    else $error("indexed word-offset address wrong");

  chk_rel_branch_only: assert property (fin_ff && mode_ff == MODE_REL |->
      opcode_ff[7:4] == NIB_REL)
    else $error("relative mode from non-branch opcode");

  chk_rel_target_step: assert property (fin_ff && mode_ff == MODE_REL |->
      ea_ff == op_addr_ff + LEN_TWO + coag_sext(byte1_ff)
      && pc_ff == (cond_ff ? ea_ff : op_addr_ff + LEN_TWO))
    else $error("relative branch target or step wrong");

  chk_bsc_address: assert property (fin_ff && mode_ff == MODE_BSC |->
      ea_ff == {ZERO_PAGE, byte1_ff} && pc_ff == op_addr_ff + LEN_TWO && bit_ff == opcode_ff[3:1])
    else $error("bit set/clear address wrong");

  chk_btb_branch: assert property (fin_ff && mode_ff == MODE_BTB |->
      tba_ff == {ZERO_PAGE, byte1_ff} && ea_ff == op_addr_ff + LEN_THREE + coag_sext(byte2_ff)
      && pc_ff == ((carry_ff == ~opcode_ff[0]) ? ea_ff : op_addr_ff + LEN_THREE))
    else $error("bit test-and-branch target or step wrong");

  chk_btb_carry_copy: assert property (state_ff == ST_OPND && rd_take |=>
      carry_valid && carry_out == $past(mem_rdata[bit_ff]))
    else $error("tested bit not copied to carry");

  // fetch order: first trailing byte, then second, then operand
  sequence s_byte1_taken;
    state_ff == ST_BYTE1 && rd_take && mode_ff inside {MODE_EXT, MODE_IX2, MODE_BTB};
  endsequence
  sequence s_byte2_taken;
    state_ff == ST_BYTE2 && rd_take && mode_ff == MODE_BTB;
  endsequence

  chk_fetch_byte_order: assert property (s_byte1_taken |=>
      state_ff == ST_BYTE2 && mem_addr_ff == op_addr_ff + LEN_TWO)
    else $error("second trailing byte fetched out of order");

  chk_operand_after: assert property (s_byte2_taken |=>
      state_ff == ST_OPND && mem_addr_ff == {ZERO_PAGE, byte1_ff})
    else $error("operand read not after trailing bytes");

  chk_first_fetch: assert property (state_ff == ST_BYTE1 |->
      mem_addr_ff == op_addr_ff + LEN_ONE)
    else $error("first trailing byte address wrong");

endmodule : coag_operand_address_generator

//--- bench/coag_mem_model.sv
// coag_mem_model: program and data memory answering the generator's reads
// assumes: one clock; bench presets bytes and sets wait_cycles between tests
`timescale 1ns/10ps
module coag_mem_model (
  input wire logic ref_clk,
  input wire logic clk_en,
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  input wire logic [3:0] wait_cycles,
  output logic mem_ready,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [3:0] wait_ff = 4'h0;
  logic [7:0] last_ff = 8'h00;

  // answer once the request has been held for the wait count
  always_comb begin
    mem_ready = mem_rd && (wait_ff >= wait_cycles);
    mem_rdata = mem_ready ? mem[mem_addr] : ~last_ff; // no stale byte off the bus
  end

  // count held cycles, remember the last byte driven
  always_ff @(posedge ref_clk) begin
    if (!mem_rd || (mem_ready && clk_en)) begin
      wait_ff <= 4'h0;
    end else if (clk_en) begin
      wait_ff <= wait_ff + 4'h1;
    end
    if (mem_ready) begin
      last_ff <= mem_rdata;
    end
  end
endmodule : coag_mem_model

//--- bench/coag_operand_address_generator_tb.sv
// coag_operand_address_generator_tb: table of addressing cases, then reset and stall cases
// assumes: coag_mem_model as memory; inputs driven 1 ns after the rising edge
`timescale 1ns/10ps
module coag_operand_address_generator_tb;
  import coag_pkg::*;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] x;
    logic cond;
    logic [15:0] pc;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] opnd;
    logic [15:0] ea;
    logic [15:0] npc;
    logic bad;
    logic cry;
    logic [1:0] nrd;
    logic cea;
  } coag_row_t;
  coag_row_t rows [0:16] = '{
    '{8'hC6, 8'h00, 1'b0, 16'h1000, 8'h12, 8'h34, 8'h00, 16'h1234, 16'h1003, 1'b0, 1'b0, 2'h2, 1'b1},
    '{8'hC6, 8'h00, 1'b0, 16'hFFFE, 8'hFF, 8'hFF, 8'h00, 16'hFFFF, 16'h0001, 1'b0, 1'b0, 2'h2, 1'b1},
    '{8'hF6, 8'hA5, 1'b0, 16'h2000, 8'h00, 8'h00, 8'h00, 16'h00A5, 16'h2001, 1'b0, 1'b0, 2'h0, 1'b1},
    '{8'h76, 8'hFF, 1'b0, 16'h2000, 8'h00, 8'h00, 8'h00, 16'h00FF, 16'h2001, 1'b0, 1'b0, 2'h0, 1'b1},
    '{8'hE6, 8'hFF, 1'b0, 16'h2100, 8'hFF, 8'h00, 8'h00, 16'h01FE, 16'h2102, 1'b0, 1'b0, 2'h1, 1'b1},
    '{8'h66, 8'h01, 1'b0, 16'h2100, 8'h10, 8'h00, 8'h00, 16'h0011, 16'h2102, 1'b0, 1'b0, 2'h1, 1'b1},
    '{8'hD6, 8'h80, 1'b0, 16'h2200, 8'h12, 8'h90, 8'h00, 16'h1310, 16'h2203, 1'b0, 1'b0, 2'h2, 1'b1},
    '{8'hD6, 8'hFF, 1'b0, 16'h2200, 8'hFF, 8'hFF, 8'h00, 16'h00FE, 16'h2203, 1'b0, 1'b0, 2'h2, 1'b1},
    '{8'h26, 8'h00, 1'b1, 16'h3000, 8'h10, 8'h00, 8'h00, 16'h3012, 16'h3012, 1'b0, 1'b0, 2'h1, 1'b1},
    '{8'h26, 8'h00, 1'b1, 16'h3000, 8'h80, 8'h00, 8'h00, 16'h2F82, 16'h2F82, 1'b0, 1'b0, 2'h1, 1'b1},
    '{8'h26, 8'h00, 1'b1, 16'h3000, 8'h7F, 8'h00, 8'h00, 16'h3081, 16'h3081, 1'b0, 1'b0, 2'h1, 1'b1},
    '{8'h26, 8'h00, 1'b0, 16'h3000, 8'h10, 8'h00, 8'h00, 16'h3012, 16'h3002, 1'b0, 1'b0, 2'h1, 1'b1},
    '{8'h13, 8'h00, 1'b0, 16'h5000, 8'h44, 8'h00, 8'h00, 16'h0044, 16'h5002, 1'b0, 1'b0, 2'h1, 1'b1},
    '{8'h0E, 8'h00, 1'b0, 16'h4000, 8'h50, 8'hFE, 8'h80, 16'h4001, 16'h4001, 1'b0, 1'b1, 2'h3, 1'b1},
    '{8'h01, 8'h00, 1'b0, 16'h4000, 8'h51, 8'h7F, 8'hFE, 16'h4082, 16'h4082, 1'b0, 1'b0, 2'h3, 1'b1},
    '{8'h00, 8'h00, 1'b0, 16'h4000, 8'h52, 8'h80, 8'hFE, 16'h3F83, 16'h4003, 1'b0, 1'b0, 2'h3, 1'b1},
    '{8'h4A, 8'h00, 1'b0, 16'h6000, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h6000, 1'b1, 1'b0, 2'h0, 1'b0}
  };
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic pc_load = 1'b0;
  logic [15:0] pc_value = 16'h0000;
  logic start = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [7:0] index_reg = 8'h00;
  logic branch_cond = 1'b0;
  logic [3:0] wait_cycles = 4'h0;
  logic mem_rd, mem_ready, busy, done, bad_mode, carry_out, carry_valid;
  logic [15:0] mem_addr, effective_address, program_counter, tested_byte_address;
  logic [7:0] mem_rdata;
  logic [2:0] bit_number;
  logic [15:0] rd_q [$];
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  coag_operand_address_generator i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
    .pc_load(pc_load), .pc_value(pc_value), .start(start), .opcode(opcode), .index_reg(index_reg),
    .branch_cond(branch_cond), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata), .busy(busy), .done(done), .bad_mode(bad_mode),
    .effective_address(effective_address), .program_counter(program_counter),
    .tested_byte_address(tested_byte_address), .bit_number(bit_number), .carry_out(carry_out),
    .carry_valid(carry_valid));
  coag_mem_model i_mem (.ref_clk(ref_clk), .clk_en(clk_en), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .wait_cycles(wait_cycles), .mem_ready(mem_ready), .mem_rdata(mem_rdata));

  // clock and hang guard
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      $display("timeout at %0t", $time);
      results();
    end
  end
  // log every read the memory takes
  always @(posedge ref_clk) begin
    if (mem_rd && mem_ready && clk_en) rd_q.push_back(mem_addr);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step

  task automatic results();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  // load pc, place bytes, issue one instruction and judge it
  task automatic run(input coag_row_t r);
    int cyc;
    logic bit_test_branch_mode;
    bit_test_branch_mode = (r.op[7:4] == 4'h0);
    pc_load = 1'b1;
    pc_value = r.pc;
    step();
    pc_load = 1'b0;
    i_mem.mem[r.pc + 16'h0001] = r.b1;
    i_mem.mem[r.pc + 16'h0002] = r.b2;
    if (bit_test_branch_mode) i_mem.mem[{8'h00, r.b1}] = r.opnd;
    rd_q.delete();
    opcode = r.op;
    index_reg = r.x;
    branch_cond = r.cond;
    start = 1'b1;
    step();
    start = 1'b0;
    cyc = 1;
    while (done !== 1'b1 && cyc < 60) begin
      step();
      cyc++;
    end
    if (wait_cycles == 4'h0) check(16'(cyc), 16'(r.nrd) + 16'h0001);
    if (r.cea) check(effective_address, r.ea);
    check(program_counter, r.npc);
    check(bad_mode, r.bad);
    check(bit_number, r.op[3:1]);
    check(carry_valid, bit_test_branch_mode);
    if (bit_test_branch_mode) check(carry_out, r.cry);
    if (bit_test_branch_mode) check(tested_byte_address, {8'h00, r.b1});
    check(16'(rd_q.size()), 16'(r.nrd));
    foreach (rd_q[i]) check(rd_q[i], (bit_test_branch_mode && i == 2) ? {8'h00, r.b1} : r.pc + 16'(i + 1));
    $display("test op=%h pc=%h finished", r.op, r.pc);
  endtask : run

  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    check({busy, done, mem_rd, bad_mode, carry_valid}, 16'h0000);
    check(program_counter, 16'h0000);
    $display("test reset values finished");
    foreach (rows[i]) run(rows[i]);
    // slow memory, a start while busy and a clock-enable gap
    wait_cycles = 4'h3;
    fork
      run(rows[6]);
      begin
        repeat (3) step();
        start = 1'b1;
        step();
        start = 1'b0;
        clk_en = 1'b0;
        repeat (3) step();
        check(mem_addr, 16'h2201);
        check(busy, 1'b1);
        clk_en = 1'b1;
      end
    join
    // pc_load wins over start
    step();
    pc_load = 1'b1;
    pc_value = 16'h7777;
    opcode = 8'hF6;
    start = 1'b1;
    step();
    pc_load = 1'b0;
    start = 1'b0;
    check(done, 1'b0);
    check(program_counter, 16'h7777);
    $display("test load over start finished");
    // reset in mid-instruction
    opcode = 8'hC6;
    start = 1'b1;
    step();
    start = 1'b0;
    repeat (2) step();
    arst_n = 1'b0;
    #1;
    check({busy, mem_rd, done}, 16'h0000);
    check(program_counter, 16'h0000);
    step();
    arst_n = 1'b1;
    wait_cycles = 4'h0;
    run(rows[0]);
    $display("test mid reset finished");
    results();
  end
endmodule : coag_operand_address_generator_tb
